/* File: hw/rpam_consts.svh */
// Constants for the register pointer and address map block
`ifndef RPAM_CONSTS_SVH
`define RPAM_CONSTS_SVH
`define RPAM_BLOCK_W      5
`define RPAM_PAGE_W       6
`define RPAM_SEG_W        6
`define RPAM_DPAGE_W      8
`define RPAM_MADDR_W      22
`define RPAM_PAGED_GROUP  4'hF
`define RPAM_LOW_PTR_RST  5'h00
`define RPAM_HIGH_PTR_RST 5'h01
`define RPAM_PAGE_RST     6'h00
`define RPAM_SEG_RST      6'h00
`define RPAM_DPAGE_RST    8'h00
`endif

/* File: hw/rpam_load_reg.sv */
// Loadable register with synchronous reset value
`timescale 1ns/1ps
module rpam_load_reg #(
  parameter int             W   = 8,
  parameter logic [W-1:0]   RST = '0
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Load port
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  // Stored value
  output logic      [W-1:0] value_q
);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      value_q <= RST;
    end else if (load) begin
      value_q <= din;
    end
  end
endmodule

/* File: hw/rpam_pkg.sv */
// Types for the register pointer and address map block
package rpam_pkg;
  typedef enum logic [4:0] {
    RPAM_ACC_FETCH = 5'h01,
    RPAM_ACC_DMA   = 5'h02,
    RPAM_ACC_INTR  = 5'h04,
    RPAM_ACC_DATA  = 5'h08,
    RPAM_ACC_PDATA = 5'h10
  } rpam_access_type;
endpackage

/* File: hw/rpam_top.sv */
// Working-register pointers, peripheral paging and 22-bit memory address extension
//
// Overview of operation
// RQ1: Split mode: r0-r7 map to low block pointer times eight plus index.
// RQ2: Split mode: r8-r15 map to high block pointer block, first to eighth.
// RQ3: Each block pointer takes 0..31, loaded by its own set instruction.
// RQ4: Top sixteen-register group is paged, up to 64 pages.
// RQ5: Group 15 accesses go to page held in the page pointer.
// RQ6: Software saves and restores the page pointer; hardware keeps no copy.
// RQ7: Block pointer pair is readable and writable as one unit.
// RQ8: Memory address output is 22 bits wide.
// RQ9: Program 64 segments of 64K, data 256 pages of 16K.
// RQ10: Fetches prefix the 16-bit address with the code segment register.
// RQ11: DMA takes upper six bits from DMA or interrupt segment register.
// RQ12: Interrupt accesses take upper bits from interrupt or code segment.
// RQ13: Data accesses take eight upper bits from one of four page registers.
// RQ14: Program-data moves use program segment extension instead of paging.
// RQ15: Single set instruction takes an even block number 0..30.
// RQ16: Data address bits 15:14 choose the data page register.
// RQ17: DMA uses DMA segment only when segment select bit is set.
// RQ18: Working-register address resolves combinationally, same cycle.
`timescale 1ns/1ps
`include "rpam_consts.svh"
module rpam_top (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // Pointer load commands from the decoder
  input  wire logic                        set_group,
  input  wire logic                        set_low_block_pointer,
  input  wire logic                        set_high_block_pointer,
  input  wire logic [`RPAM_BLOCK_W-1:0]    block_num,
  input  wire logic                        load_block_pointer_pair,
  input  wire logic [15:0]                 block_pointer_pair_in,
  input  wire logic                        load_peripheral_page_pointer,
  input  wire logic [`RPAM_PAGE_W-1:0]     page_num,
  // Segment and page register loads
  input  wire logic                        load_code_segment_reg,
  input  wire logic                        load_dma_segment_reg,
  input  wire logic                        load_interrupt_segment_reg,
  input  wire logic [`RPAM_SEG_W-1:0]      seg_in,
  input  wire logic [3:0]                  load_data_page_regs,
  input  wire logic [`RPAM_DPAGE_W-1:0]    dpage_in,
  // Register operand resolution
  input  wire logic                        wreg_access,
  input  wire logic [3:0]                  wreg_num,
  input  wire logic [7:0]                  abs_reg_in,
  output logic      [7:0]                  reg_addr,
  output logic                             reg_paged,
  output logic      [`RPAM_PAGE_W-1:0]     reg_page,
  // Memory address extension
  input  wire rpam_pkg::rpam_access_type   access_kind,
  input  wire logic                        dma_segment_select,
  input  wire logic                        intr_uses_code_seg,
  input  wire logic [15:0]                 logical_addr,
  output logic      [`RPAM_MADDR_W-1:0]    mem_addr,
  // Pointer state readback
  output logic      [15:0]                 block_pointer_pair,
  output logic      [`RPAM_PAGE_W-1:0]     peripheral_page_pointer,
  output logic                             split_mode
);
  //////////////////////////////////////////////////////////////////////////////
  // Block pointers
  logic [`RPAM_BLOCK_W-1:0] low_block_pointer;
  logic [`RPAM_BLOCK_W-1:0] high_block_pointer;
  logic                     split_q;
  logic                     split_d;
  logic [`RPAM_BLOCK_W-1:0] even_block;
  logic [`RPAM_BLOCK_W-1:0] low_d;
  logic [`RPAM_BLOCK_W-1:0] high_d;
  logic                     low_ld;
  logic                     high_ld;

  // Group select forces even block, high pointer follows as odd
  assign even_block = {block_num[`RPAM_BLOCK_W-1:1], 1'b0}; // RQ15
  assign low_ld  = set_group | set_low_block_pointer | load_block_pointer_pair;  // RQ3
  assign high_ld = set_group | set_high_block_pointer | load_block_pointer_pair; // RQ3
  // Pair packs each pointer in bits 7:3 of its byte, bit 0 of low byte is split
  assign low_d  = load_block_pointer_pair ? block_pointer_pair_in[7:3] :
                  set_group ? even_block : block_num; // RQ7
  assign high_d = load_block_pointer_pair ? block_pointer_pair_in[15:11] :
                  set_group ? (even_block | 5'h01) : block_num; // RQ7
  assign split_d = load_block_pointer_pair ? block_pointer_pair_in[0] :
                   set_group ? 1'b0 :
                   (set_low_block_pointer | set_high_block_pointer) ? 1'b1 : split_q;

  rpam_load_reg #(.W(`RPAM_BLOCK_W), .RST(`RPAM_LOW_PTR_RST)) u_low (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (low_ld),
    .din      (low_d),
    .value_q  (low_block_pointer)
  );
  rpam_load_reg #(.W(`RPAM_BLOCK_W), .RST(`RPAM_HIGH_PTR_RST)) u_high (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (high_ld),
    .din      (high_d),
    .value_q  (high_block_pointer)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      split_q <= 1'b0;
    end else begin
      split_q <= split_d;
    end
  end

  assign block_pointer_pair = {high_block_pointer, 3'h0, low_block_pointer, 2'h0, split_q}; // RQ7
  assign split_mode = split_q;

  //////////////////////////////////////////////////////////////////////////////
  // Peripheral page pointer, software-managed across routines
  rpam_load_reg #(.W(`RPAM_PAGE_W), .RST(`RPAM_PAGE_RST)) u_page (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (load_peripheral_page_pointer),
    .din      (page_num),
    .value_q  (peripheral_page_pointer)
  ); // RQ6

  //////////////////////////////////////////////////////////////////////////////
  // Register operand resolution, purely combinational
  logic [`RPAM_BLOCK_W-1:0] sel_block;
  assign sel_block = wreg_num[3] ? high_block_pointer : low_block_pointer; // RQ1 RQ2
  assign reg_addr  = wreg_access ? {sel_block, wreg_num[2:0]} : abs_reg_in; // RQ1 RQ2 RQ18
  assign reg_paged = (reg_addr[7:4] == `RPAM_PAGED_GROUP); // RQ4 RQ5
  assign reg_page  = peripheral_page_pointer; // RQ5

  //////////////////////////////////////////////////////////////////////////////
  // Segment and data page registers
  logic [`RPAM_SEG_W-1:0]   code_segment_reg;
  logic [`RPAM_SEG_W-1:0]   dma_segment_reg;
  logic [`RPAM_SEG_W-1:0]   interrupt_segment_reg;
  logic [`RPAM_DPAGE_W-1:0] data_page_regs [4];

  rpam_load_reg #(.W(`RPAM_SEG_W), .RST(`RPAM_SEG_RST)) u_cseg (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (load_code_segment_reg),
    .din      (seg_in),
    .value_q  (code_segment_reg)
  );
  rpam_load_reg #(.W(`RPAM_SEG_W), .RST(`RPAM_SEG_RST)) u_dseg (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (load_dma_segment_reg),
    .din      (seg_in),
    .value_q  (dma_segment_reg)
  );
  rpam_load_reg #(.W(`RPAM_SEG_W), .RST(`RPAM_SEG_RST)) u_iseg (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (load_interrupt_segment_reg),
    .din      (seg_in),
    .value_q  (interrupt_segment_reg)
  );
  for (genvar i = 0; i < 4; i++) begin : g_dpr
    rpam_load_reg #(.W(`RPAM_DPAGE_W), .RST(`RPAM_DPAGE_RST)) u_dpr (
      .core_clk (core_clk),
      .rst      (rst),
      .load     (load_data_page_regs[i]),
      .din      (dpage_in),
      .value_q  (data_page_regs[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // 22-bit address formation
  logic [`RPAM_SEG_W-1:0]   dma_seg;
  logic [`RPAM_SEG_W-1:0]   intr_seg;
  logic [`RPAM_DPAGE_W-1:0] data_page;
  assign dma_seg   = dma_segment_select ? dma_segment_reg : interrupt_segment_reg; // RQ11 RQ17
  assign intr_seg  = intr_uses_code_seg ? code_segment_reg : interrupt_segment_reg; // RQ12
  assign data_page = data_page_regs[logical_addr[15:14]]; // RQ13 RQ16

  always_comb begin
    mem_addr = {code_segment_reg, logical_addr};
    unique case (access_kind)
      rpam_pkg::RPAM_ACC_FETCH: mem_addr = {code_segment_reg, logical_addr}; // RQ8 RQ9 RQ10
      rpam_pkg::RPAM_ACC_DMA:   mem_addr = {dma_seg, logical_addr}; // RQ11
      rpam_pkg::RPAM_ACC_INTR:  mem_addr = {intr_seg, logical_addr}; // RQ12
      rpam_pkg::RPAM_ACC_DATA:  mem_addr = {data_page, logical_addr[13:0]}; // RQ9 RQ13
      rpam_pkg::RPAM_ACC_PDATA: mem_addr = {code_segment_reg, logical_addr}; // RQ14
      default:                  mem_addr = {code_segment_reg, logical_addr};
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_low_set;
    set_low_block_pointer && !set_group && !load_block_pointer_pair;
  endsequence

  low_ptr_load_a: assert property (@(posedge core_clk) disable iff (rst)
    s_low_set |=> (low_block_pointer == $past(block_num)) && split_mode) // RQ3
    else $error("low block pointer not loaded");
  group_even_a: assert property (@(posedge core_clk) disable iff (rst)
    set_group && !load_block_pointer_pair |=> !split_mode && !low_block_pointer[0]
      && high_block_pointer == (low_block_pointer | 5'h01)) // RQ15
    else $error("group select not even/odd pair");
  wreg_low_map_a: assert property (@(posedge core_clk) disable iff (rst)
    wreg_access && !wreg_num[3] |-> reg_addr == {low_block_pointer, wreg_num[2:0]}) // RQ1
    else $error("low working register mis-mapped");
  wreg_high_map_a: assert property (@(posedge core_clk) disable iff (rst)
    wreg_access && wreg_num[3] |-> reg_addr == {high_block_pointer, wreg_num[2:0]}) // RQ2
    else $error("high working register mis-mapped");
  paged_group_a: assert property (@(posedge core_clk) disable iff (rst)
    reg_paged |-> reg_addr[7:4] == 4'hF && reg_page == peripheral_page_pointer) // RQ5
    else $error("paged group routing wrong");
  page_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    !load_peripheral_page_pointer |=> $stable(peripheral_page_pointer)) // RQ6
    else $error("page pointer changed without load");
  pair_round_a: assert property (@(posedge core_clk) disable iff (rst)
    load_block_pointer_pair |=> block_pointer_pair[15:11] == $past(block_pointer_pair_in[15:11])
      && block_pointer_pair[7:3] == $past(block_pointer_pair_in[7:3])) // RQ7
    else $error("pointer pair not loaded as a unit");
  fetch_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    access_kind == rpam_pkg::RPAM_ACC_FETCH |-> mem_addr[21:16] == code_segment_reg) // RQ10
    else $error("fetch segment wrong");
  dma_seg_a: assert property (@(posedge core_clk) disable iff (rst)
    access_kind == rpam_pkg::RPAM_ACC_DMA |-> mem_addr[21:16] ==
      (dma_segment_select ? dma_segment_reg : interrupt_segment_reg)) // RQ17
    else $error("dma segment wrong");
  data_page_a: assert property (@(posedge core_clk) disable iff (rst)
    access_kind == rpam_pkg::RPAM_ACC_DATA |-> mem_addr[21:14] == data_page_regs[logical_addr[15:14]]
      && mem_addr[13:0] == logical_addr[13:0]) // RQ16
    else $error("data page extension wrong");
endmodule

/* File: sim/rpam_core_model.sv */
// Decoder-side model that issues one-cycle pointer and segment load pulses
`timescale 1ns/1ps
module rpam_core_model (
  // Clock
  input wire logic core_clk
);
  // Wait for the edge, then move inputs a fixed delay after it
  task automatic step();
    @(posedge core_clk);
    #10;
  endtask

  // Raises the selected load pulses for exactly one taken edge
  task automatic cmd(input logic [11:0] c);
    step();
    {tb.set_group, tb.set_low_block_pointer, tb.set_high_block_pointer, tb.load_block_pointer_pair,
     tb.load_peripheral_page_pointer, tb.load_code_segment_reg, tb.load_dma_segment_reg,
     tb.load_interrupt_segment_reg, tb.load_data_page_regs} = c;
    step();
    {tb.set_group, tb.set_low_block_pointer, tb.set_high_block_pointer, tb.load_block_pointer_pair,
     tb.load_peripheral_page_pointer, tb.load_code_segment_reg, tb.load_dma_segment_reg,
     tb.load_interrupt_segment_reg, tb.load_data_page_regs} = 12'h000;
  endtask
endmodule

/* File: sim/tb.sv */
// Self-checking bench for register pointers, paging and address extension
`timescale 1ns/1ps
`include "rpam_consts.svh"
module tb;
  localparam logic [11:0] C_G = 12'h800, C_LO = 12'h400, C_HI = 12'h200, C_PAIR = 12'h100;
  localparam logic [11:0] C_PPP = 12'h080, C_CS = 12'h040, C_DMA = 12'h020, C_INT = 12'h010;
  logic                      core_clk, rst, set_group, set_low_block_pointer, set_high_block_pointer;
  logic                      load_block_pointer_pair, load_peripheral_page_pointer, load_code_segment_reg;
  logic                      load_dma_segment_reg, load_interrupt_segment_reg, wreg_access;
  logic                      dma_segment_select, intr_uses_code_seg, reg_paged, split_mode;
  logic [3:0]                load_data_page_regs, wreg_num;
  logic [4:0]                block_num;
  logic [5:0]                page_num, seg_in, reg_page, peripheral_page_pointer;
  logic [7:0]                dpage_in, abs_reg_in, reg_addr;
  logic [15:0]               block_pointer_pair_in, logical_addr, block_pointer_pair;
  logic [21:0]               mem_addr;
  rpam_pkg::rpam_access_type access_kind;
  int                        err_count, samples_checked, cycles;

  rpam_core_model core_inst (.core_clk(core_clk));
  rpam_top rpam_top_inst (.core_clk(core_clk), .rst(rst), .set_group(set_group),
    .set_low_block_pointer(set_low_block_pointer), .set_high_block_pointer(set_high_block_pointer),
    .block_num(block_num), .load_block_pointer_pair(load_block_pointer_pair),
    .block_pointer_pair_in(block_pointer_pair_in), .load_peripheral_page_pointer(load_peripheral_page_pointer),
    .page_num(page_num), .load_code_segment_reg(load_code_segment_reg), .load_dma_segment_reg(load_dma_segment_reg),
    .load_interrupt_segment_reg(load_interrupt_segment_reg), .seg_in(seg_in),
    .load_data_page_regs(load_data_page_regs), .dpage_in(dpage_in), .wreg_access(wreg_access),
    .wreg_num(wreg_num), .abs_reg_in(abs_reg_in), .reg_addr(reg_addr), .reg_paged(reg_paged),
    .reg_page(reg_page), .access_kind(access_kind), .dma_segment_select(dma_segment_select),
    .intr_uses_code_seg(intr_uses_code_seg), .logical_addr(logical_addr), .mem_addr(mem_addr),
    .block_pointer_pair(block_pointer_pair), .peripheral_page_pointer(peripheral_page_pointer),
    .split_mode(split_mode));

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Operand change lands one fixed delay after an edge
  task automatic wreg(input logic [3:0] n, input logic [7:0] exp);
    core_inst.step();
    wreg_access = 1'b1;
    wreg_num = n;
    #1 check(reg_addr, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_split();
    for (int i = 0; i < 16; i++) begin
      if (i == 0) begin
        block_num = 5'h02;
        core_inst.cmd(C_LO);
        block_num = 5'h1B;
        core_inst.cmd(C_HI);
        check(split_mode, 1'b1);
      end
      wreg(4'(i), (i < 8) ? 8'(16 + i) : 8'(208 + i));
    end
    block_num = 5'h1F;
    core_inst.cmd(C_LO);
    block_num = 5'h00;
    core_inst.cmd(C_HI);
    check(block_pointer_pair, 16'h00F9);
    wreg(4'h7, 8'hFF);
    wreg(4'h8, 8'h00);
  endtask

  task automatic t_group_pair();
    block_num = 5'h05;
    core_inst.cmd(C_G);
    check(block_pointer_pair, 16'h2820);
    wreg(4'h3, 8'h23);
    wreg(4'hC, 8'h2C);
    block_pointer_pair_in = 16'h48A1;
    block_num = 5'h03;
    core_inst.cmd(C_PAIR | C_LO);
    check(block_pointer_pair, 16'h48A1);
    wreg(4'h1, 8'hA1);
    wreg(4'h9, 8'h49);
  endtask

  task automatic t_page();
    page_num = 6'h3F;
    core_inst.cmd(C_PPP);
    check(peripheral_page_pointer, 6'h3F);
    check(reg_page, 6'h3F);
    wreg_access = 1'b0;
    abs_reg_in = 8'hF5;
    #1 check({reg_paged, reg_addr}, 9'h1F5);
    page_num = 6'h15;
    core_inst.cmd(C_PPP);
    abs_reg_in = 8'hE5;
    #1 check({reg_paged, reg_page, reg_addr}, 15'h15E5);
    block_num = 5'h1E;
    core_inst.cmd(C_G);
    wreg(4'h2, 8'hF2);
    check(reg_paged, 1'b1);
  endtask

  task automatic t_mem();
    seg_in = 6'h2A;
    core_inst.cmd(C_CS);
    seg_in = 6'h15;
    core_inst.cmd(C_DMA);
    seg_in = 6'h3F;
    core_inst.cmd(C_INT);
    for (int i = 0; i < 4; i++) begin
      dpage_in = 8'(32 + i);
      core_inst.cmd(12'(1 << i));
    end
    logical_addr = 16'h25A5;
    #1 check(mem_addr, {6'h2A, 16'h25A5});
    access_kind = rpam_pkg::RPAM_ACC_PDATA;
    #1 check(mem_addr, 22'h2A25A5);
    // A code that is not one-hot falls back to the fetch mapping
    access_kind = rpam_pkg::rpam_access_type'(5'h03);
    #1 check(mem_addr, 22'h2A25A5);
    access_kind = rpam_pkg::RPAM_ACC_DMA;
    dma_segment_select = 1'b1;
    #1 check(mem_addr, 22'h1525A5);
    dma_segment_select = 1'b0;
    #1 check(mem_addr, 22'h3F25A5);
    access_kind = rpam_pkg::RPAM_ACC_INTR;
    intr_uses_code_seg = 1'b1;
    #1 check(mem_addr, 22'h2A25A5);
    intr_uses_code_seg = 1'b0;
    #1 check(mem_addr, 22'h3F25A5);
    access_kind = rpam_pkg::RPAM_ACC_DATA;
    for (int i = 0; i < 4; i++) begin
      core_inst.step();
      logical_addr = {2'(i), 14'h25A5};
      #1 check(mem_addr, {8'(32 + i), 14'h25A5});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    {rst, set_group, set_low_block_pointer, set_high_block_pointer, load_block_pointer_pair} = 5'h10;
    {load_peripheral_page_pointer, load_code_segment_reg, load_dma_segment_reg} = 3'h0;
    {load_interrupt_segment_reg, load_data_page_regs, wreg_access, wreg_num} = 10'h000;
    {dma_segment_select, intr_uses_code_seg, block_num, page_num, seg_in} = 19'h00000;
    {dpage_in, abs_reg_in, block_pointer_pair_in, logical_addr} = 48'h0;
    access_kind = rpam_pkg::RPAM_ACC_FETCH;
    {err_count, samples_checked, cycles} = '0;
    repeat (10) core_inst.step();
    rst = 1'b0;
    check({block_pointer_pair, peripheral_page_pointer}, 22'h020000);
    check(split_mode, 1'b0);
    wreg(4'hB, 8'h0B);
    t_split();
    t_group_pair();
    t_page();
    t_mem();
    finish_test();
  end
endmodule
